/* File: hbn_pkg.sv */
// constants, states and decode helpers for the 16-bit non-multiplexed host-bus port
`default_nettype none
package hbn_pkg;
	localparam int DATA_W  = 16;
	localparam int ADDR_W  = 20;
	localparam int CS_MAX  = 4;
	localparam int CNT_W   = 4;

	// mode selections
	localparam logic [3:0] PORT_MODE_HB16 = 4'h3;
	localparam logic [1:0] HB_MODE_NONMUX = 2'h1;
	localparam logic       BYTE_SEL_OFF   = 1'h1;

	// select arrangements
	localparam logic [3:0] SEL_ALE_ONLY   = 4'h0;
	localparam logic [3:0] SEL_ONE_CS     = 4'h1;
	localparam logic [3:0] SEL_TWO_CS     = 4'h2;
	localparam logic [3:0] SEL_ALE_TWO_CS = 4'h3;
	localparam logic [3:0] SEL_THREE_CS   = 4'h5;
	localparam logic [3:0] SEL_FOUR_CS    = 4'h7;

	// address reach per arrangement
	localparam logic [ADDR_W-1:0] MASK_12 = 20'h00FFF;
	localparam logic [ADDR_W-1:0] MASK_11 = 20'h007FF;
	localparam logic [ADDR_W-1:0] MASK_10 = 20'h003FF;
	localparam logic [ADDR_W-1:0] MASK_EXT = 20'hFFFFF;

	// idle levels of the active-low strobes, reset values of data and address
	localparam logic [CS_MAX-1:0] CS_IDLE_N   = 4'hF;
	localparam logic [1:0]        BYTE_LANE_SELECT_IDLE_N = 2'h3;
	localparam logic [DATA_W-1:0] DATA_RST    = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST    = 20'h00000;

	// timing, least times rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 100;
	localparam int STROBE_NS     = 300;
	localparam int HOLD_NS       = 100;
	localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} hbn_state_e;

	// number of chip selects; zero also marks an illegal code
	function automatic logic [2:0] cs_count(input logic [3:0] sel);
		case (sel)
			SEL_ONE_CS:     cs_count = 3'h1;
			SEL_TWO_CS:     cs_count = 3'h2;
			SEL_ALE_TWO_CS: cs_count = 3'h2;
			SEL_THREE_CS:   cs_count = 3'h3;
			SEL_FOUR_CS:    cs_count = 3'h4;
			default:        cs_count = 3'h0;
		endcase
	endfunction

	function automatic logic has_ale(input logic [3:0] sel);
		has_ale = (sel == SEL_ALE_ONLY) || (sel == SEL_ALE_TWO_CS);
	endfunction

	// the latch-only arrangement has no pin left for ready
	function automatic logic uses_ready(input logic [3:0] sel);
		uses_ready = (sel != SEL_ALE_ONLY);
	endfunction

	function automatic logic [ADDR_W-1:0] addr_mask(input logic [3:0] sel);
		case (sel)
			SEL_TWO_CS:     addr_mask = MASK_11;
			SEL_ALE_TWO_CS: addr_mask = MASK_10;
			SEL_THREE_CS:   addr_mask = MASK_EXT;
			SEL_FOUR_CS:    addr_mask = MASK_EXT;
			default:        addr_mask = MASK_12;
		endcase
	endfunction
endpackage
`default_nettype wire

/* File: hbn_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module hbn_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output var  logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_nxt;

	// first stage feeds only the second stage
	always_comb begin
		meta_nxt = i_async;
		sync_nxt = meta_r;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= meta_nxt;
			o_sync <= sync_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: hbn_port.sv */
// 16-bit non-multiplexed host-bus master port
`timescale 1ns/1ps
`default_nettype none
module hbn_port (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst_n,
	input  wire logic [3:0]                 i_port_mode_config,
	input  wire logic [1:0]                 i_hostbus_mode,
	input  wire logic                       i_byte_sel_cfg,
	input  wire logic [3:0]                 i_select_arrangement_field,
	input  wire logic                       i_req_valid,
	input  wire logic                       i_req_write,
	input  wire logic [hbn_pkg::ADDR_W-1:0] i_req_addr,
	input  wire logic [1:0]                 i_req_sel,
	input  wire logic [1:0]                 i_req_lanes,
	input  wire logic [hbn_pkg::DATA_W-1:0] i_req_wdata,
	output var  logic                       o_req_ready,
	output var  logic                       o_rsp_valid,
	output var  logic                       o_rsp_err,
	output var  logic [hbn_pkg::DATA_W-1:0] o_rsp_rdata,
	output var  logic                       o_port_active,
	output var  logic [hbn_pkg::ADDR_W-1:0] o_addr,
	output var  logic [hbn_pkg::DATA_W-1:0] o_data,
	output var  logic                       o_data_oe_n,
	input  wire logic [hbn_pkg::DATA_W-1:0] i_data,
	output var  logic                       o_ale,
	output var  logic                       o_rd_n,
	output var  logic                       o_wr_n,
	output var  logic [hbn_pkg::CS_MAX-1:0] o_cs_n,
	output var  logic [1:0]                 o_byte_lane_select_n,
	input  wire logic                       i_rdy
);
	localparam logic [hbn_pkg::CNT_W-1:0] STRB_LOAD = hbn_pkg::CNT_W'(hbn_pkg::STROBE_CYC - 1);
	localparam logic [hbn_pkg::CNT_W-1:0] HOLD_LOAD = hbn_pkg::CNT_W'(hbn_pkg::HOLD_CYC - 1);
	localparam logic [hbn_pkg::CNT_W-1:0] CNT_ZERO  = '0;

	hbn_pkg::hbn_state_e          state_r;
	hbn_pkg::hbn_state_e          state_nxt;
	logic [hbn_pkg::CNT_W-1:0]    cnt_r;
	logic [hbn_pkg::CNT_W-1:0]    cnt_nxt;
	logic [3:0]                   sel_cfg_r;
	logic [3:0]                   sel_cfg_nxt;
	logic                         byte_lane_select_off_r;
	logic                         byte_lane_select_off_nxt;
	logic                         write_r;
	logic                         write_nxt;
	logic                         ready_nxt;
	logic                         rsp_valid_nxt;
	logic                         rsp_err_nxt;
	logic [hbn_pkg::DATA_W-1:0]   rdata_nxt;
	logic                         active_nxt;
	logic [hbn_pkg::ADDR_W-1:0]   addr_nxt;
	logic [hbn_pkg::DATA_W-1:0]   data_nxt;
	logic                         oe_n_nxt;
	logic                         ale_nxt;
	logic                         rd_n_nxt;
	logic                         wr_n_nxt;
	logic [hbn_pkg::CS_MAX-1:0]   cs_n_nxt;
	logic [hbn_pkg::CS_MAX-1:0]   cs_hold_r;
	logic [hbn_pkg::CS_MAX-1:0]   cs_hold_nxt;
	logic [1:0]                   byte_lane_select_n_nxt;
	logic [hbn_pkg::DATA_W-1:0]   data_s;
	logic                         rdy_s;
	logic                         cfg_ok;
	logic [2:0]                   cs_cnt_live;
	logic                         sel_bad;
	logic                         rdy_ok;

	// pin inputs cross two flops before any logic looks at them
	hbn_sync #(
		.WIDTH(hbn_pkg::DATA_W)
	) u_data_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n  (i_rst_n),
		.i_async  (i_data),
		.o_sync   (data_s)
	);

	hbn_sync #(
		.WIDTH(1)
	) u_rdy_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n  (i_rst_n),
		.i_async  (i_rdy),
		.o_sync   (rdy_s)
	);

	// live configuration decode; illegal arrangement codes keep the port shut
	always_comb begin
		cs_cnt_live = hbn_pkg::cs_count(i_select_arrangement_field);
		cfg_ok = (i_port_mode_config == hbn_pkg::PORT_MODE_HB16)
			&& (i_hostbus_mode == hbn_pkg::HB_MODE_NONMUX)
			&& (hbn_pkg::has_ale(i_select_arrangement_field) || (cs_cnt_live != 3'h0));
		// a select index beyond the configured count has no pin to drive
		sel_bad = (cs_cnt_live != 3'h0) && ({1'b0, i_req_sel} >= cs_cnt_live);
		// ready only counts where the arrangement routes it
		rdy_ok = !hbn_pkg::uses_ready(sel_cfg_r) || rdy_s;
	end

	// bus sequencer: setup (latch), strobe, hold
	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		sel_cfg_nxt   = sel_cfg_r;
		byte_lane_select_off_nxt  = byte_lane_select_off_r;
		write_nxt     = write_r;
		cs_hold_nxt   = cs_hold_r;
		ready_nxt     = 1'b0;
		rsp_valid_nxt = 1'b0;
		rsp_err_nxt   = 1'b0;
		rdata_nxt     = o_rsp_rdata;
		active_nxt    = cfg_ok;
		addr_nxt      = o_addr;
		data_nxt      = o_data;
		oe_n_nxt      = o_data_oe_n;
		ale_nxt       = 1'b0;
		rd_n_nxt      = 1'b1;
		wr_n_nxt      = 1'b1;
		cs_n_nxt      = o_cs_n;
		byte_lane_select_n_nxt    = o_byte_lane_select_n;
		unique case (state_r)
			hbn_pkg::ST_IDLE: begin
				ready_nxt = cfg_ok;
				if (o_req_ready && i_req_valid && cfg_ok) begin
					if (sel_bad) begin
						rsp_valid_nxt = 1'b1;
						rsp_err_nxt   = 1'b1;
						ready_nxt     = 1'b0;
					end else begin
						sel_cfg_nxt  = i_select_arrangement_field;
						byte_lane_select_off_nxt = (i_byte_sel_cfg == hbn_pkg::BYTE_SEL_OFF);
						write_nxt    = i_req_write;
						// reach shrinks with the arrangement
						addr_nxt = i_req_addr & hbn_pkg::addr_mask(i_select_arrangement_field);
						data_nxt = i_req_wdata;
						// write data goes out on its own pins from setup on
						oe_n_nxt = !i_req_write;
						// latch pulse in the setup cycle, ahead of any strobe
						ale_nxt = hbn_pkg::has_ale(i_select_arrangement_field);
						// one-hot select from the request index
						cs_hold_nxt = (cs_cnt_live == 3'h0) ? hbn_pkg::CS_IDLE_N
							: ~(hbn_pkg::CS_MAX'(1) << i_req_sel);
						cs_n_nxt = cs_hold_nxt;
						// byte lanes, or both inactive when disabled
						byte_lane_select_n_nxt = (i_byte_sel_cfg == hbn_pkg::BYTE_SEL_OFF)
							? hbn_pkg::BYTE_LANE_SELECT_IDLE_N : ~i_req_lanes;
						ready_nxt = 1'b0;
						state_nxt = hbn_pkg::ST_SETUP;
					end
				end
			end
			hbn_pkg::ST_SETUP: begin
				// exactly one strobe per cycle kind
				rd_n_nxt  = write_r;
				wr_n_nxt  = !write_r;
				cnt_nxt   = STRB_LOAD;
				state_nxt = hbn_pkg::ST_STROBE;
			end
			hbn_pkg::ST_STROBE: begin
				rd_n_nxt = o_rd_n;
				wr_n_nxt = o_wr_n;
				if (cnt_r != CNT_ZERO) begin
					cnt_nxt = cnt_r - 1'b1;
				end else if (rdy_ok) begin
					// peripheral done: release strobe, answer
					rd_n_nxt      = 1'b1;
					wr_n_nxt      = 1'b1;
					rdata_nxt     = write_r ? o_rsp_rdata : data_s;
					rsp_valid_nxt = 1'b1;
					cnt_nxt       = HOLD_LOAD;
					state_nxt     = hbn_pkg::ST_HOLD;
				end
			end
			hbn_pkg::ST_HOLD: begin
				// address and selects stay through hold so the latch sees them
				if (cnt_r != CNT_ZERO) begin
					cnt_nxt = cnt_r - 1'b1;
				end else begin
					cs_n_nxt   = hbn_pkg::CS_IDLE_N;
					byte_lane_select_n_nxt = hbn_pkg::BYTE_LANE_SELECT_IDLE_N;
					oe_n_nxt   = 1'b1;
					ready_nxt  = cfg_ok;
					state_nxt  = hbn_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// every pin and answer comes straight from a flop
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r              <= hbn_pkg::ST_IDLE;
			cnt_r                <= CNT_ZERO;
			sel_cfg_r            <= hbn_pkg::SEL_ALE_ONLY;
			byte_lane_select_off_r           <= hbn_pkg::BYTE_SEL_OFF;
			write_r              <= 1'b0;
			cs_hold_r            <= hbn_pkg::CS_IDLE_N;
			o_req_ready          <= 1'b0;
			o_rsp_valid          <= 1'b0;
			o_rsp_err            <= 1'b0;
			o_rsp_rdata          <= hbn_pkg::DATA_RST;
			o_port_active        <= 1'b0;
			o_addr               <= hbn_pkg::ADDR_RST;
			o_data               <= hbn_pkg::DATA_RST;
			o_data_oe_n          <= 1'b1;
			o_ale                <= 1'b0;
			o_rd_n               <= 1'b1;
			o_wr_n               <= 1'b1;
			o_cs_n               <= hbn_pkg::CS_IDLE_N;
			o_byte_lane_select_n <= hbn_pkg::BYTE_LANE_SELECT_IDLE_N;
		end else begin
			state_r              <= state_nxt;
			cnt_r                <= cnt_nxt;
			sel_cfg_r            <= sel_cfg_nxt;
			byte_lane_select_off_r           <= byte_lane_select_off_nxt;
			write_r              <= write_nxt;
			cs_hold_r            <= cs_hold_nxt;
			o_req_ready          <= ready_nxt;
			o_rsp_valid          <= rsp_valid_nxt;
			o_rsp_err            <= rsp_err_nxt;
			o_rsp_rdata          <= rdata_nxt;
			o_port_active        <= active_nxt;
			o_addr               <= addr_nxt;
			o_data               <= data_nxt;
			o_data_oe_n          <= oe_n_nxt;
			o_ale                <= ale_nxt;
			o_rd_n               <= rd_n_nxt;
			o_wr_n               <= wr_n_nxt;
			o_cs_n               <= cs_n_nxt;
			o_byte_lane_select_n <= byte_lane_select_n_nxt;
		end
	end

	// checks on the pins this port drives
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	logic strb_on;
	assign strb_on = !o_rd_n || !o_wr_n;

	strobe_excl_a: assert property (
		!(!o_rd_n && !o_wr_n))
		else $error("read and write strobes active together");

	ale_first_a: assert property (
		$rose(strb_on) && hbn_pkg::has_ale(sel_cfg_r) |-> $past(o_ale))
		else $error("strobe without preceding latch pulse");

	addr_stable_a: assert property (
		strb_on |=> $stable(o_addr) || !strb_on)
		else $error("address moved during data phase");

	cs_onehot_a: assert property (
		$onehot0(~o_cs_n))
		else $error("more than one chip select active");

	addr_reach_a: assert property (
		strb_on |-> (o_addr & ~hbn_pkg::addr_mask(sel_cfg_r)) == hbn_pkg::ADDR_RST)
		else $error("address beyond configured reach");

	byte_lane_select_off_a: assert property (
		strb_on && byte_lane_select_off_r |-> o_byte_lane_select_n == hbn_pkg::BYTE_LANE_SELECT_IDLE_N)
		else $error("byte selects driven while disabled");

	mode_gate_a: assert property (
		!cfg_ok |=> !o_req_ready)
		else $error("port ready outside host-bus non-mux mode");

	strobe_len_a: assert property (
		$fell(o_rd_n) |-> !o_rd_n [*3])
		else $error("read strobe shorter than minimum");

	ready_wait_a: assert property (
		strb_on && hbn_pkg::uses_ready(sel_cfg_r) && !rdy_s |=> strb_on)
		else $error("strobe ended while peripheral not ready");

	write_drive_a: assert property (
		!o_wr_n |-> !o_data_oe_n ##0 (o_rd_n))
		else $error("write strobe without data drive");

	read_cov: cover property ($rose(o_rsp_valid) && !write_r);
	write_cov: cover property ($fell(o_wr_n));
	stretch_cov: cover property (strb_on && !rdy_s ##1 strb_on ##1 !strb_on);
	err_cov: cover property (o_rsp_err);
endmodule
`default_nettype wire

/* File: hbn_periph.sv */
// behavioural external peripheral: small word memory with ready stretch
`timescale 1ns/1ps
`default_nettype none
module hbn_periph (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic [19:0] i_addr,
	input  wire logic [15:0] i_data,
	input  wire logic        i_ale,
	input  wire logic        i_rd_n,
	input  wire logic        i_wr_n,
	input  wire logic [3:0]  i_cs_n,
	input  wire logic [1:0]  i_lane_n,
	input  wire logic [3:0]  i_wait_cyc,
	output var  logic [15:0] o_data,
	output var  logic        o_rdy
);
	logic [15:0] mem [16];
	logic [19:0] lat_r;
	logic [15:0] last_r;
	logic [3:0]  wait_r;
	logic        strb_r;
	logic        strb;
	logic [3:0]  idx;
	// latch-only bus has no select, so the latched address is used
	assign idx = (i_cs_n == 4'hF) ? lat_r[3:0] : i_addr[3:0];
	assign strb = !i_rd_n || !i_wr_n;
	// released bus shows the inverse of the last value, never a stale copy
	assign o_data = !i_rd_n ? mem[idx] : ~last_r;
	// ready drops on the strobe's first cycle so the sync delay cannot hide it
	assign o_rdy = (wait_r == 4'h0) && !(strb && !strb_r && i_wait_cyc != 4'h0);
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lat_r <= 20'h00000;
			last_r <= 16'h0000;
			wait_r <= 4'h0;
			strb_r <= 1'b0;
		end else begin
			strb_r <= strb;
			if (i_ale)
				lat_r <= i_addr;
			if (!i_rd_n)
				last_r <= mem[idx];
			if (strb && !strb_r && i_wait_cyc != 4'h0)
				wait_r <= i_wait_cyc - 4'h1;
			else if (wait_r != 4'h0)
				wait_r <= wait_r - 4'h1;
			// both selects high means byte selects are off: whole word
			if (!i_wr_n && (!i_lane_n[0] || i_lane_n == 2'h3))
				mem[idx][7:0] <= i_data[7:0];
			if (!i_wr_n && (!i_lane_n[1] || i_lane_n == 2'h3))
				mem[idx][15:8] <= i_data[15:8];
		end
	end
endmodule
`default_nettype wire

/* File: hbn_port_tb.sv */
// self-checking bench for the non-multiplexed host-bus port
`timescale 1ns/1ps
`default_nettype none
module hbn_port_tb;
	typedef struct {logic [3:0] arr; logic [1:0] sel; logic [19:0] a; logic [19:0] ea; logic [15:0] wd;} hbn_row_s;
	localparam int TMO = 5000;
	hbn_row_s rows [6] = '{
		'{4'h0, 2'h0, 20'h12345, 20'h00345, 16'h1111},
		'{4'h1, 2'h0, 20'hFF006, 20'h00006, 16'h2222},
		'{4'h2, 2'h1, 20'hABFF7, 20'h007F7, 16'h3333},
		'{4'h3, 2'h1, 20'hFFFF8, 20'h003F8, 16'h4444},
		'{4'h5, 2'h2, 20'hABCD9, 20'hABCD9, 16'h5555},
		'{4'h7, 2'h3, 20'h5432A, 20'h5432A, 16'h6666}};
	logic        clk, rst_n, valid, wr, bcfg, ale, rd_n, wr_n, oe_n, rdy;
	logic [3:0]  pmode, arr, wcyc, cs_n;
	logic [1:0]  hmode, sel, lanes, ln_n;
	logic [19:0] addr, o_addr;
	logic [15:0] wdata, o_data, i_data;
	logic        ready, rsp, err, act, e_seen, a_seen, oe_seen;
	logic [15:0] rdata, r_seen, d_seen;
	logic [19:0] ad_seen;
	logic [3:0]  cs_seen;
	logic [1:0]  ln_seen;
	int          fails, num_checks, cyc, scnt;
	hbn_port u_hbn_port (.i_ref_clk(clk), .i_rst_n(rst_n), .i_port_mode_config(pmode), .i_hostbus_mode(hmode),
		.i_byte_sel_cfg(bcfg), .i_select_arrangement_field(arr), .i_req_valid(valid), .i_req_write(wr),
		.i_req_addr(addr), .i_req_sel(sel), .i_req_lanes(lanes), .i_req_wdata(wdata), .o_req_ready(ready),
		.o_rsp_valid(rsp), .o_rsp_err(err), .o_rsp_rdata(rdata), .o_port_active(act), .o_addr(o_addr),
		.o_data(o_data), .o_data_oe_n(oe_n), .i_data(i_data), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_cs_n(cs_n), .o_byte_lane_select_n(ln_n), .i_rdy(rdy));
	hbn_periph u_hbn_periph (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(o_addr), .i_data(o_data), .i_ale(ale),
		.i_rd_n(rd_n), .i_wr_n(wr_n), .i_cs_n(cs_n), .i_lane_n(ln_n), .i_wait_cyc(wcyc), .o_data(i_data),
		.o_rdy(rdy));
	// free-running clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard; one access takes well under 20 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == TMO) begin
			fails++;
			complete_run();
		end
	end
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one access; pin values are recorded while a strobe is low
	task automatic access(input logic w, input logic [19:0] a, input logic [1:0] s, input logic [1:0] l,
		input logic [15:0] d);
		int n;
		n = 0;
		scnt = 0;
		a_seen = 1'b0;
		cs_seen = 4'hF;
		valid <= 1'b1;
		wr <= w;
		addr <= a;
		sel <= s;
		lanes <= l;
		wdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'b1 && n < 50);
		chk(ready, 20'h1);
		valid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
			if (ale === 1'b1)
				a_seen = 1'b1;
			if (rd_n === 1'b0 && wr_n === 1'b0)
				chk(20'h1, 20'h0);
			if (rd_n === 1'b0 || wr_n === 1'b0) begin
				scnt++;
				cs_seen = cs_n;
				ad_seen = o_addr;
				d_seen = o_data;
				oe_seen = oe_n;
				ln_seen = ln_n;
			end
		end while (rsp !== 1'b1 && n < 100);
		// a local limit that runs out counts as a mismatch here
		chk(rsp, 20'h1);
		e_seen = err;
		r_seen = rdata;
	endtask
	initial begin
		{rst_n, valid, wr, lanes, sel, addr, wdata, wcyc} = '0;
		{pmode, hmode, bcfg, arr} = {4'h3, 2'h1, 1'b1, 4'h0};
		repeat (16) @(posedge clk);
		chk({ready, rd_n, wr_n, ale, oe_n, cs_n}, {5'h0D, 4'hF});
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(ready, 20'h1);
		$display("reset test done");
		// table: write then read back in every arrangement
		foreach (rows[i]) begin
			arr <= rows[i].arr;
			repeat (2) @(posedge clk);
			access(1'b1, rows[i].a, rows[i].sel, 2'h3, rows[i].wd);
			chk(ad_seen, rows[i].ea);
			chk(cs_seen, rows[i].arr == 4'h0 ? 4'hF : 4'(~(4'h1 << rows[i].sel)));
			chk(a_seen, rows[i].arr == 4'h0 || rows[i].arr == 4'h3);
			chk({d_seen, oe_seen, ln_seen}, {rows[i].wd, 3'h3});
			chk(scnt[19:0], 20'h3);
			access(1'b0, rows[i].a, rows[i].sel, 2'h3, 16'h0000);
			chk({r_seen, oe_seen, e_seen}, {rows[i].wd, 2'h2});
			chk(cs_seen, rows[i].arr == 4'h0 ? 4'hF : 4'(~(4'h1 << rows[i].sel)));
		end
		$display("table test done");
		// byte lanes: lower-only write then whole-word read
		bcfg <= 1'b0;
		arr <= 4'h1;
		@(posedge clk);
		access(1'b1, 20'h00006, 2'h0, 2'h1, 16'hAAAA);
		chk(ln_seen, 2'h2);
		access(1'b0, 20'h00006, 2'h0, 2'h3, 16'h0000);
		chk({r_seen, 2'h0, ln_seen}, {16'h22AA, 4'h0});
		$display("byte lane test done");
		// select out of range is refused without a bus cycle
		access(1'b0, 20'h00006, 2'h1, 2'h3, 16'h0000);
		chk({e_seen, 1'b0, scnt[3:0]}, 6'h20);
		$display("bad select test done");
		// slow peripheral stretches; latch-only arrangement ignores ready
		wcyc <= 4'h6;
		arr <= 4'h2;
		@(posedge clk);
		access(1'b0, 20'h00007, 2'h1, 2'h3, 16'h0000);
		chk({r_seen, 3'h0, scnt > 6}, {16'h3333, 4'h1});
		arr <= 4'h0;
		@(posedge clk);
		access(1'b0, 20'h00005, 2'h0, 2'h3, 16'h0000);
		chk({r_seen, scnt[3:0]}, {16'h1111, 4'h3});
		wcyc <= 4'h0;
		$display("ready test done");
		// illegal port or bus mode keeps the port idle
		pmode <= 4'h2;
		repeat (3) @(posedge clk);
		chk({act, ready}, 2'h0);
		pmode <= 4'h3;
		hmode <= 2'h0;
		repeat (3) @(posedge clk);
		chk({act, ready}, 2'h0);
		hmode <= 2'h1;
		repeat (3) @(posedge clk);
		chk({act, ready}, 2'h3);
		// an undefined arrangement code must keep the port shut
		arr <= 4'h4;
		repeat (3) @(posedge clk);
		chk({act, ready}, 2'h0);
		$display("mode test done");
		// mid-run reset: pins fall back at once, port ready one edge after release
		arr <= 4'h0;
		rst_n <= 1'b0;
		@(posedge clk);
		chk({ready, rd_n, wr_n, ale, oe_n, cs_n}, {5'h0D, 4'hF});
		chk(o_addr, 20'h00000);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk({act, ready}, 2'h3);
		access(1'b0, 20'h00005, 2'h0, 2'h3, 16'h0000);
		chk(r_seen, 16'h1111);
		$display("mid-run reset test done");
		complete_run();
	end
endmodule
`default_nettype wire
